// ### src/bus_reset_suspend_cfg.svh
// constants for the bus reset and suspend controller
// assumes inclusion by bare name from the package and the design module
`ifndef BUS_RESET_SUSPEND_CFG_SVH
`define BUS_RESET_SUSPEND_CFG_SVH

// width and reset value of the bus-facing configuration register
`define CFG_W 32
`define CFG_RST 32'h0000_0000

// width and reset value of the wake-event context register
`define CTX_W 8
`define CTX_RST 8'h00

// idle (deasserted) level of an active-low pin; the synchronisers reset to its inverse
`define PIN_IDLE_N 1'b1

`endif

// ### src/bus_reset_suspend_pkg.sv
// types shared by the bus reset and suspend controller
// assumes the constants header is on the include path
`include "bus_reset_suspend_cfg.svh"

package bus_reset_suspend_pkg;

    // reset and suspend pins, as seen at the device edge
    typedef struct packed {
        logic global_reset_in_n;
        logic bus_reset_in_n;
        logic suspend_in;
    } reset_pins_s;

    // user-side write and wake-event requests
    typedef struct packed {
        logic wr_en;
        logic [`CFG_W-1:0] wr_data;
        logic [`CTX_W-1:0] wake_set;
        logic [`CTX_W-1:0] wake_clr;
    } core_req_s;

    // operating state of the device logic
    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_RUN
    } run_state_e;

endpackage : bus_reset_suspend_pkg

// ### src/bus_reset_suspend_control.sv
// reset and suspend handling for the bus side of the device
// assumes mclk_i is the bus clock and the pins arrive unsynchronised
//
// Functional notes
// - global reset floats all outputs and clears every internal register
// - with suspend, global reset floats outputs but preserves registers
// - bus signals sampled on rising edge of the bus clock
// - bus reset floats outputs, clears config but keeps wake context, device nonfunctional
// - after bus reset release device comes up in default state
// - suspend with bus reset keeps registers, outputs stay floating
`timescale 1ns/1ps
`default_nettype none
`include "bus_reset_suspend_cfg.svh"

module bus_reset_suspend_control
    import bus_reset_suspend_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire reset_pins_s pins_i,
    input wire core_req_s req_i,
    output logic [`CFG_W-1:0] bus_data_o,
    output logic bus_oe_n_o,
    output logic [`CTX_W-1:0] wake_ctx_o,
    output logic func_ready_o
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0] pin_raw;
    logic [2:0] sync1_q;
    logic [2:0] sync1_d;
    logic [2:0] sync2_q;
    logic [2:0] sync2_d;

    // pin bits in struct order: global, bus, suspend
    assign pin_raw = pins_i;

    // two stages per pin; stage one feeds stage two only
    generate
        for (genvar b = 0; b < 3; b++) begin : g_sync
            always_comb begin
                sync1_d[b] = pin_raw[b];
                sync2_d[b] = sync1_q[b];
            end
        end
    endgenerate

    // until the pins have crossed, both resets read as asserted, so no
    // run state leaks out while a pin may still be held low at power-on
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_q <= {~`PIN_IDLE_N, ~`PIN_IDLE_N, 1'b0};
            sync2_q <= {~`PIN_IDLE_N, ~`PIN_IDLE_N, 1'b0};
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded reset conditions

    logic glob_rst_act;
    logic bus_rst_act;
    logic susp_act;
    logic any_rst;
    logic clear_all;
    logic clear_cfg;

    // synchronised view of the pins
    always_comb begin
        glob_rst_act = ~sync2_q[2];
        bus_rst_act = ~sync2_q[1];
        susp_act = sync2_q[0];
        any_rst = glob_rst_act | bus_rst_act;
        clear_all = glob_rst_act & ~susp_act;
        clear_cfg = any_rst & ~susp_act;
    end

    ////////////////////////////////////////////////////////////////////////
    // operating state

    run_state_e st_q;
    run_state_e st_d;

    // reset wins, suspend only picks which reset flavour
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RESET, ST_HOLD, ST_RUN: begin
                if (any_rst && susp_act) begin
                    st_d = ST_HOLD;
                end else if (any_rst) begin
                    st_d = ST_RESET;
                end else begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal registers

    logic [`CFG_W-1:0] cfg_q;
    logic [`CFG_W-1:0] cfg_d;
    logic [`CTX_W-1:0] ctx_q;
    logic [`CTX_W-1:0] ctx_d;

    // without suspend, config clears on either reset; wake context only on global reset,
    // so a bus reset between sleep states keeps pending wake events
    always_comb begin
        cfg_d = cfg_q;
        ctx_d = ctx_q;
        if (clear_cfg) begin
            cfg_d = `CFG_RST;
        end else if (!any_rst && st_q == ST_RUN && req_i.wr_en) begin
            cfg_d = req_i.wr_data;
        end
        if (clear_all) begin
            ctx_d = `CTX_RST;
        end else if (!any_rst) begin
            // set beats a clear in the same cycle
            ctx_d = (ctx_q & ~req_i.wake_clr) | req_i.wake_set;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cfg_q <= `CFG_RST;
            ctx_q <= `CTX_RST;
        end else begin
            cfg_q <= cfg_d;
            ctx_q <= ctx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // raw pins force the float without a clock edge; the synced view keeps
    // it floating until the release has crossed the synchroniser
    always_comb begin
        bus_oe_n_o = ~rst_n_i | ~pins_i.global_reset_in_n
                   | ~pins_i.bus_reset_in_n | any_rst | (st_q != ST_RUN);
    end

    // data comes straight from the registers
    assign bus_data_o = cfg_q;
    assign wake_ctx_o = ctx_q;
    assign func_ready_o = (st_q == ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_glob_clears_all: assert property (
        glob_rst_act && !susp_act |=> cfg_q == `CFG_RST && ctx_q == `CTX_RST
    ) else $error("global reset did not clear registers");

    chk_glob_default: assert property (
        glob_rst_act && !susp_act |=> !func_ready_o && bus_oe_n_o
    ) else $error("global reset left device running or driving");

    chk_glob_susp_keep: assert property (
        glob_rst_act && susp_act |=> $stable(cfg_q) && $stable(ctx_q)
    ) else $error("suspend did not shield registers from global reset");

    chk_bus_clears_cfg: assert property (
        bus_rst_act && !susp_act |=> cfg_q == `CFG_RST && !func_ready_o
    ) else $error("bus reset did not clear config or left device running");

    chk_bus_keeps_ctx: assert property (
        bus_rst_act && !glob_rst_act |=> $stable(ctx_q)
    ) else $error("bus reset disturbed wake context");

    chk_bus_susp_keep: assert property (
        bus_rst_act && susp_act |=> $stable(cfg_q) && bus_oe_n_o
    ) else $error("suspend with bus reset lost registers or drove outputs");

    chk_rst_not_ready: assert property (
        any_rst |=> !func_ready_o
    ) else $error("device reported ready while a reset was active");

    chk_rst_refuse_write: assert property (
        any_rst && req_i.wr_en |=> cfg_q == `CFG_RST || $stable(cfg_q)
    ) else $error("write taken while a reset was active");

    // state follows one edge after the synced release
    chk_release_default: assert property (
        $fell(any_rst) |=> func_ready_o
            && bus_oe_n_o == (!pins_i.global_reset_in_n || !pins_i.bus_reset_in_n)
    ) else $error("device not running after reset release");

    chk_wake_set_wins: assert property (
        !any_rst && req_i.wake_set != '0
            |=> (wake_ctx_o & $past(req_i.wake_set)) == $past(req_i.wake_set)
    ) else $error("wake set bit not taken on the clock edge");

    chk_float_async: assert property (
        !pins_i.global_reset_in_n || !pins_i.bus_reset_in_n |-> bus_oe_n_o
    ) else $error("outputs driven while a reset pin is low");

    chk_write_on_edge: assert property (
        req_i.wr_en && st_q == ST_RUN && !any_rst |=> cfg_q == $past(req_i.wr_data)
    ) else $error("write not taken on the clock edge");

endmodule : bus_reset_suspend_control
`default_nettype wire

// ### verif/reset_host_model.sv
// host-side reset logic model driving the reset and suspend pins
// assumes bench commands, pins launched only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module reset_host_model
    import bus_reset_suspend_pkg::*;
(
    input wire logic mclk_i,
    input wire logic glob_i,
    input wire logic bus_i,
    input wire logic susp_i,
    output var reset_pins_s pins_o
);
    ////////////////////////////////////////////////////////////////////////////
    // boot starts with the global reset held low
    initial pins_o = 3'b010;
    // pins move on the rising edge only, so the device never sees a race
    always @(posedge mclk_i) begin
        pins_o.global_reset_in_n <= !glob_i;
        pins_o.bus_reset_in_n <= !bus_i;
        pins_o.suspend_in <= susp_i;
    end
endmodule : reset_host_model
`default_nettype wire

// ### verif/bus_reset_suspend_control_bench.sv
// bench for the reset and suspend controller
// assumes a 250 MHz bus clock and the host model on the reset pins
`timescale 1ns/1ps
`default_nettype none
module bus_reset_suspend_control_bench
    import bus_reset_suspend_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic glob = 1'b1;
    logic busr = 1'b0;
    logic susp = 1'b0;
    core_req_s req = '0;
    reset_pins_s pins;
    logic [31:0] data;
    logic oe_n;
    logic [7:0] ctx;
    logic rdy;
    int fail_count = 0;
    int num_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    // 4 ns bus clock
    always #2 mclk_i = ~mclk_i;
    reset_host_model reset_host_model_inst (.mclk_i(mclk_i), .glob_i(glob), .bus_i(busr),
        .susp_i(susp), .pins_o(pins));
    bus_reset_suspend_control bus_reset_suspend_control_inst (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .pins_i(pins), .req_i(req), .bus_data_o(data),
        .bus_oe_n_o(oe_n), .wake_ctx_o(ctx), .func_ready_o(rdy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [31:0] d);
        @(posedge mclk_i);
        req.wr_en <= 1'b1;
        req.wr_data <= d;
        @(posedge mclk_i);
        req.wr_en <= 1'b0;
        #1;
    endtask : wr
    // pins follow one edge later, through the host model
    task automatic set_pins(input logic g, input logic b, input logic s);
        @(posedge mclk_i);
        glob <= g;
        busr <= b;
        susp <= s;
        @(posedge mclk_i);
        #1;
    endtask : set_pins
    // bounded wait for the device to run again after a release
    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check("ready", rdy, 32'h1);
        check("oe_n run", oe_n, 32'h0);
        if (rdy !== 1'b1) wrap_up();
    endtask : wait_ready
    // one reset pulse; a write in mid-reset must be refused
    task automatic hit(input string nm, input logic g, input logic s,
        input logic [31:0] d, input logic [7:0] c);
        set_pins(g, !g, s);
        check("oe_n held", oe_n, 32'h1);
        repeat (2) @(posedge mclk_i);
        wr(32'h0bad_0bad);
        check("ready low", rdy, 32'h0);
        check("cfg", data, d);
        check("ctx", {24'h0, ctx}, {24'h0, c});
        set_pins(1'b0, 1'b0, 1'b0);
        check("oe_n release", oe_n, 32'h1);
        wait_ready();
        check("cfg after", data, d);
        $display("done %s", nm);
    endtask : hit
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write();
        wr(32'hc3a5_0f10);
        check("write", data, 32'hc3a5_0f10);
        // set and clear on bit 0 in one cycle: the set must win
        @(posedge mclk_i);
        req.wake_set <= 8'h81;
        req.wake_clr <= 8'h01;
        @(posedge mclk_i);
        req.wake_set <= 8'h00;
        #1;
        check("wake set wins", {24'h0, ctx}, 32'h81);
        @(posedge mclk_i);
        req.wake_clr <= 8'h00;
        #1;
        check("wake clear", {24'h0, ctx}, 32'h80);
        @(posedge mclk_i);
        req.wake_set <= 8'h01;
        @(posedge mclk_i);
        req.wake_set <= 8'h00;
        #1;
        check("wake set", {24'h0, ctx}, 32'h81);
        $display("done write");
    endtask : t_write
    task automatic t_bus();
        hit("bus", 1'b0, 1'b0, 32'h0, 8'h81);
    endtask : t_bus
    task automatic t_bus_susp();
        wr(32'h5a5a_1234);
        hit("bus suspend", 1'b0, 1'b1, 32'h5a5a_1234, 8'h81);
    endtask : t_bus_susp
    task automatic t_glob_susp();
        hit("global suspend", 1'b1, 1'b1, 32'h5a5a_1234, 8'h81);
    endtask : t_glob_susp
    task automatic t_glob();
        hit("global", 1'b1, 1'b0, 32'h0, 8'h00);
    endtask : t_glob
    ////////////////////////////////////////////////////////////////////////////
    // boot: power-on reset, global reset held, then both let go
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        check("oe_n boot", oe_n, 32'h1);
        set_pins(1'b0, 1'b0, 1'b0);
        wait_ready();
        t_write();
        t_bus();
        t_bus_susp();
        t_glob_susp();
        t_glob();
        wrap_up();
    end
endmodule : bus_reset_suspend_control_bench
`default_nettype wire
